// ---- design/cpp_regs.vh ----
`ifndef CPP_REGS_VH
`define CPP_REGS_VH

// clock rate and wait delay
`define CPP_CLK_HZ            10000000
`define CPP_MWAIT_MIN_US      30
`define CPP_MWAIT_MAX_US      300
// 30 us at 10 MHz, least time as an exact cycle count
`define CPP_MWAIT_CYC         ((`CPP_MWAIT_MIN_US * (`CPP_CLK_HZ / 1000000)))
`define CPP_MWAIT_W           12
// memory clear length in cycles
`define CPP_CLEAR_CYC         12'h040
// widths
`define CPP_ADDR_W            18
`define CPP_DATA_W            8
// byte processing time while busy
`define CPP_BUSY_CYC          4'h8
// mode codes on mode_select_pins
`define CPP_MODE_MPAR_UP      3'h4
`define CPP_MODE_MPAR_DN      3'h6
`define CPP_MODE_PERIPH       3'h5
`define CPP_MODE_EXPRESS      3'h1
`define CPP_MODE_MSER         3'h0
// status byte while read strobe low: d6..d0 high
`define CPP_STATUS_LOW        7'h7F
`define CPP_ADDR_ZERO         18'h00000
`define CPP_ADDR_TOP          18'h3FFFF
`define CPP_ADDR_ONE          18'h00001

`endif

// ---- design/cpp_sync2.v ----
`timescale 1ns/1ps
`default_nettype none
module cpp_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // pins in, synced out
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule // cpp_sync2
`default_nettype wire

// ---- design/cpp_config_port.v ----
// Notes on behaviour
// - init line driven low during power settle and configuration memory clearing.
// - external low on init holds the wait state; configuration waits for high.
// - master modes wait a further 30 to 300 us after init rises.
// - during configuration, init pulled low reports a data error.
// - selected only when low select is low and high select is high; express mode takes bytes on high select alone.
// - write strobe low while selected loads the data byte into the buffer.
// - read strobe low drives ready/busy on top bit, other bits high.
// - both strobes low: write performed, read ignored.
// - express mode uses high select as serial enable along the chain.
// - master parallel drives 18 rom address outputs.
// - after completion init, data and rom address pins are released to user logic; the address clock is driven low.
// - mode pins sampled after init goes high choose the mode.
// - master parallel gives address clock rising edge before each address change.
`include "cpp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module cpp_config_port (
  // clock and reset
  input  wire                     sys_clk,
  input  wire                     rst,
  // init handshake pin
  input  wire                     init_n_in,
  output reg                      init_n_out,
  output reg                      init_n_oe,
  // mode pins
  input  wire [2:0]               mode_select_pins,
  // peripheral byte interface
  input  wire                     chip_select_low_n,
  input  wire                     chip_select_high,
  input  wire                     write_strobe_n,
  input  wire                     read_strobe_n,
  input  wire [`CPP_DATA_W-1:0]   config_data_byte_in,
  output reg  [`CPP_DATA_W-1:0]   config_data_byte_out,
  output reg                      config_data_byte_oe,
  // rom side
  output reg  [`CPP_ADDR_W-1:0]   config_rom_address,
  output reg                      config_rom_address_oe,
  output reg                      addr_clk_out,
  // internal byte sink
  output reg  [`CPP_DATA_W-1:0]   byte_data,
  output reg                      byte_valid,
  input  wire                     data_error,
  input  wire                     config_done,
  // status
  output reg  [2:0]               mode_latched,
  output reg                      configuring,
  output reg                      released
);

  localparam ST_CLEAR = 3'h0;
  localparam ST_WAIT  = 3'h1;
  localparam ST_MWAIT = 3'h2;
  localparam ST_LOAD  = 3'h3;
  localparam ST_DONE  = 3'h4;

  // all pins from outside pass two flops
  // sync flops reset high, the idle level of both strobes and of low select
  wire [17:0] pins_s;
  cpp_sync2 #(.W(18)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   ({init_n_in,
                mode_select_pins,
                chip_select_low_n,
                chip_select_high,
                write_strobe_n,
                read_strobe_n,
                config_data_byte_in,
                data_error,
                config_done}),
    .sync_out (pins_s)
  );
  wire       init_s     = pins_s[17];
  wire [2:0] mode_s     = pins_s[16:14];
  wire       sel_low_s  = pins_s[13];
  wire       sel_high_s = pins_s[12];
  wire       wstb_s     = pins_s[11];
  wire       rstb_s     = pins_s[10];
  wire [7:0] d_s        = pins_s[9:2];
  wire       err_s      = pins_s[1];
  wire       done_s     = pins_s[0];

  reg [2:0]               state_reg;
  reg [`CPP_MWAIT_W-1:0]  cnt_reg;
  reg [3:0]               busy_reg;
  reg                     wstb_d_reg;
  reg                     err_reg;
  reg                     aclk_phase_reg;

  wire selected   = ~sel_low_s & sel_high_s;
  wire express    = (mode_latched == `CPP_MODE_EXPRESS);
  wire periph     = (mode_latched == `CPP_MODE_PERIPH);
  wire mpar       = (mode_latched == `CPP_MODE_MPAR_UP) |
                    (mode_latched == `CPP_MODE_MPAR_DN);
  // express: high select alone enables this device in the chain
  wire enable     = express ? sel_high_s : selected;
  wire wstb_fall  = ~wstb_s & wstb_d_reg;
  // ready once the busy count loaded by the last byte has run down to zero
  wire ready_busy_flag = (busy_reg == 4'h0);
  // write taken on the falling strobe so one low pulse gives one byte
  wire do_write   = (state_reg == ST_LOAD) & (periph | express) &
                    enable & wstb_fall;
  // write wins when both strobes are low
  wire do_read    = ~rstb_s & wstb_s & (state_reg == ST_LOAD) &
                    periph & selected;

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg             <= ST_CLEAR;
      cnt_reg               <= {`CPP_MWAIT_W{1'b0}};
      busy_reg              <= 4'h0;
      wstb_d_reg            <= 1'b1;
      err_reg               <= 1'b0;
      aclk_phase_reg        <= 1'b0;
      init_n_out            <= 1'b0;
      init_n_oe             <= 1'b1;
      config_data_byte_out  <= 8'hFF;
      config_data_byte_oe   <= 1'b0;
      config_rom_address    <= `CPP_ADDR_ZERO;
      config_rom_address_oe <= 1'b0;
      addr_clk_out          <= 1'b0;
      byte_data             <= 8'h00;
      byte_valid            <= 1'b0;
      mode_latched          <= 3'h0;
      configuring           <= 1'b0;
      released              <= 1'b0;
    end else begin
      wstb_d_reg <= wstb_s;
      byte_valid <= 1'b0;
      case (state_reg)
        ST_CLEAR: begin
          // hold init low while memory clears
          init_n_oe <= 1'b1;
          if (cnt_reg == `CPP_CLEAR_CYC) begin
            cnt_reg   <= {`CPP_MWAIT_W{1'b0}};
            init_n_oe <= 1'b0;
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_WAIT: begin
          // outside party may keep init low; stay until it rises
          // mode pins latched on the cycle init is first seen high
          if (init_s) begin
            mode_latched <= mode_s;
            cnt_reg      <= {`CPP_MWAIT_W{1'b0}};
            state_reg    <= mode_s[0] ? ST_LOAD : ST_MWAIT;
            configuring  <= mode_s[0];
          end
        end
        ST_MWAIT: begin
          // rom start address: top when counting down, zero otherwise
          if (mode_latched == `CPP_MODE_MPAR_DN) begin
            config_rom_address <= `CPP_ADDR_TOP;
          end else begin
            config_rom_address <= `CPP_ADDR_ZERO;
          end
          // least delay used; counter sized for the upper bound
          if (cnt_reg == `CPP_MWAIT_CYC - 1) begin
            state_reg             <= ST_LOAD;
            configuring           <= 1'b1;
            config_rom_address_oe <= mpar;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_LOAD: begin
          // sticky: a bad byte keeps init low until done
          if (err_s | err_reg) begin
            err_reg    <= 1'b1;
            init_n_oe  <= 1'b1;
            init_n_out <= 1'b0;
          end
          // busy spans the internal processing of each byte
          if (do_write) begin
            byte_data  <= d_s;
            byte_valid <= 1'b1;
            busy_reg   <= `CPP_BUSY_CYC;
          end else if (busy_reg != 4'h0) begin
            busy_reg <= busy_reg - 1'b1;
          end
          // status byte: ready high on the top bit
          config_data_byte_oe  <= do_read;
          config_data_byte_out <= {ready_busy_flag, `CPP_STATUS_LOW};
          if (mpar) begin
            // rising clock first, then address advances next cycle
            aclk_phase_reg <= ~aclk_phase_reg;
            addr_clk_out   <= ~aclk_phase_reg;
            if (aclk_phase_reg) begin
              byte_data  <= d_s;
              byte_valid <= 1'b1;
              if (mode_latched == `CPP_MODE_MPAR_DN)
                config_rom_address <= config_rom_address - `CPP_ADDR_ONE;
              else
                config_rom_address <= config_rom_address + `CPP_ADDR_ONE;
            end
          end
          if (done_s) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          // hand init, data and rom address pins to user logic; address clock driven low
          init_n_oe             <= 1'b0;
          config_data_byte_oe   <= 1'b0;
          config_rom_address_oe <= 1'b0;
          addr_clk_out          <= 1'b0;
          configuring           <= 1'b0;
          // released holds until the next reset
          released              <= 1'b1;
        end
        default: begin
          state_reg <= ST_CLEAR;
        end
      endcase
    end
  end
endmodule // cpp_config_port
`default_nettype wire

// ---- dv/cpp_config_port_sva.sv ----
`include "cpp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module cpp_config_port_sva (
  // clock and reset
  input wire logic        sys_clk, rst,
  // pins
  input wire logic        init_n_in, init_n_out, init_n_oe, chip_select_low_n, chip_select_high,
  input wire logic        write_strobe_n, read_strobe_n, config_data_byte_oe, data_error,
  input wire logic [7:0]  config_data_byte_in, config_data_byte_out, byte_data,
  // status and rom side
  input wire logic        byte_valid, configuring, released, config_rom_address_oe, addr_clk_out,
  input wire logic [2:0]  mode_latched,
  input wire logic [17:0] config_rom_address
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_drive; init_n_oe |-> !init_n_out; endproperty
  a_drive: assert property (p_drive) else $error("init driven high");
  property p_hold; $rose(configuring) |-> $past(init_n_in, 3); endproperty
  a_hold: assert property (p_hold) else $error("start under init hold");
  property p_mwait; $rose(configuring) && !mode_latched[0] |-> $past(init_n_in, 300); endproperty
  a_mwait: assert property (p_mwait) else $error("master wait short");
  property p_err; $rose(data_error) && configuring |-> ##[1:4] init_n_oe; endproperty
  a_err: assert property (p_err) else $error("error not flagged");
  property p_sel; byte_valid && mode_latched == `CPP_MODE_PERIPH
    |-> !$past(chip_select_low_n, 3) && $past(chip_select_high, 3); endproperty
  a_sel: assert property (p_sel) else $error("byte taken unselected");
  property p_data; byte_valid && mode_latched[0] |-> byte_data == $past(config_data_byte_in, 3);
  endproperty
  a_data: assert property (p_data) else $error("byte value wrong");
  property p_stat; config_data_byte_oe |-> config_data_byte_out[6:0] == 7'h7F
    && !$past(read_strobe_n, 3) && $past(write_strobe_n, 3); endproperty
  a_stat: assert property (p_stat) else $error("status drive wrong");
  property p_step; $changed(config_rom_address) && config_rom_address_oe
    |-> $past(addr_clk_out) && !$past(addr_clk_out, 2); endproperty
  a_step: assert property (p_step) else $error("address step without clock");
  property p_free; released |-> !(init_n_oe || config_data_byte_oe || config_rom_address_oe);
  endproperty
  a_free: assert property (p_free) else $error("pins not released");
  c_byte: cover property (byte_valid);
  c_ready: cover property (config_data_byte_oe && config_data_byte_out[7]);
  c_rel: cover property ($rose(released));
endmodule // cpp_config_port_sva
bind cpp_config_port cpp_config_port_sva u_sva (.sys_clk, .rst, .init_n_in, .init_n_out,
  .init_n_oe, .chip_select_low_n, .chip_select_high, .write_strobe_n, .read_strobe_n,
  .config_data_byte_oe, .data_error, .config_data_byte_in, .config_data_byte_out, .byte_data,
  .byte_valid, .configuring, .released, .config_rom_address_oe, .addr_clk_out, .mode_latched,
  .config_rom_address);
`default_nettype wire

// ---- dv/cpp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpp_host_model (
  // clock and rom side
  input wire logic         sys_clk,
  input wire logic         rom_mode,
  input wire logic [17:0]  rom_addr,
  input wire logic [7:0]   status_in,
  // strobes and data
  output var logic         wstb_n,
  output var logic         rstb_n,
  output wire logic [7:0]  data
);
  logic [7:0] d_reg = 8'h00;
  initial wstb_n = 1'b1;
  initial rstb_n = 1'b1;
  // idle bus shows inverse of last byte, never a stale match
  assign data = rom_mode ? (rom_addr[7:0] ^ 8'h96) : d_reg;
  task automatic wr(input logic [7:0] v, input logic both);
    @(posedge sys_clk);
    wstb_n <= 1'b0;
    rstb_n <= ~both;
    d_reg <= v;
    repeat (4) @(posedge sys_clk);
    wstb_n <= 1'b1;
    rstb_n <= 1'b1;
    d_reg <= ~v;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(output logic [7:0] s);
    @(posedge sys_clk);
    rstb_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    s = status_in;
    rstb_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // cpp_host_model
`default_nettype wire

// ---- dv/cpp_config_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpp_config_port_bench;
  logic sys_clk = 1'b0, rst = 1'b1, hold = 1'b1, data_error = 1'b0, config_done = 1'b0;
  logic chip_select_low_n = 1'b0, chip_select_high = 1'b1;
  logic [2:0] mode_select_pins = 3'h5;
  logic [7:0] got, s;
  logic [17:0] a0;
  int error_cnt = 0, n_compared = 0, nb = 0, k;
  wire logic init_n_oe, write_strobe_n, read_strobe_n, config_data_byte_oe;
  wire logic byte_valid, configuring, released, config_rom_address_oe;
  wire logic [7:0] config_data_byte_in, config_data_byte_out, byte_data;
  wire logic [2:0] mode_latched;
  wire logic [17:0] config_rom_address;
  // open-drain init with pull-up
  wire logic init_n_in = !(init_n_oe || hold);
  always #50 sys_clk = ~sys_clk;
  cpp_config_port dut (.sys_clk, .rst, .init_n_in, .init_n_out(), .init_n_oe, .mode_select_pins,
    .chip_select_low_n, .chip_select_high, .write_strobe_n, .read_strobe_n, .config_data_byte_in,
    .config_data_byte_out, .config_data_byte_oe, .config_rom_address, .config_rom_address_oe,
    .addr_clk_out(), .byte_data, .byte_valid, .data_error, .config_done, .mode_latched,
    .configuring, .released);
  cpp_host_model host (.sys_clk, .rom_mode(!mode_latched[0] && configuring),
    .rom_addr(config_rom_address), .status_in(config_data_byte_oe ? config_data_byte_out : 8'h00),
    .wstb_n(write_strobe_n), .rstb_n(read_strobe_n), .data(config_data_byte_in));
  always @(posedge sys_clk) if (byte_valid) begin
    got <= byte_data;
    nb <= nb + 1;
  end
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bring_up(input logic [2:0] m);
    @(posedge sys_clk);
    mode_select_pins <= m;
    hold <= 1'b1;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(init_n_oe, 1'b1);
    repeat (100) @(posedge sys_clk);
    chk(configuring, 1'b0);
    hold <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(mode_latched, m);
  endtask
  task automatic t_periph();
    bring_up(3'h5);
    host.wr(8'h3C, 1'b0);
    chk(got, 8'h3C);
    host.rd(s);
    chk(s[6:0], 7'h7F);
    repeat (8) @(posedge sys_clk);
    host.rd(s);
    chk(s, 8'hFF);
    k = nb;
    chip_select_high <= 1'b0;
    host.wr(8'h11, 1'b0);
    chip_select_high <= 1'b1;
    chip_select_low_n <= 1'b1;
    host.wr(8'h22, 1'b0);
    chip_select_low_n <= 1'b0;
    chk(18'(nb - k), 0);
    host.wr(8'h5A, 1'b1);
    chk(got, 8'h5A);
    data_error <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(init_n_oe, 1'b1);
    config_done <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk({released, init_n_oe}, 2'b10);
    data_error <= 1'b0;
    config_done <= 1'b0;
  endtask
  task automatic t_express();
    bring_up(3'h1);
    chip_select_low_n <= 1'b1;
    host.wr(8'hC3, 1'b0);
    chk(got, 8'hC3);
    chip_select_low_n <= 1'b0;
  endtask
  task automatic t_master(input logic [2:0] m, input logic [17:0] e);
    bring_up(m);
    chk(configuring, 1'b0);
    repeat (280) @(posedge sys_clk);
    chk(configuring, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(configuring, 1'b1);
    chk(config_rom_address_oe, 1'b1);
    a0 = config_rom_address;
    repeat (10) @(posedge sys_clk);
    chk(config_rom_address - a0, e);
  endtask
  initial begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    t_periph();
    t_express();
    t_master(3'h4, 18'h00005);
    t_master(3'h6, 18'h3FFFB);
    close_out();
  end
endmodule // cpp_config_port_bench
`default_nettype wire
